// >>> logic/scan_port_map.svh
// Constants for the boundary-scan test port and its controller
`ifndef SCAN_PORT_MAP_SVH
`define SCAN_PORT_MAP_SVH
`define IR_LEN          3
`define IR_CAPTURE_PAT  3'h1
`define INSN_EXTEST     3'h0
`define INSN_IDCODE     3'h1
`define INSN_SAMPLE_Z   3'h2
`define INSN_SAMPLE     3'h4
`define INSN_BYPASS     3'h7
`define ID_LEN          32
`define BSR_LEN         89
`define BSR_OE_BIT      88
`define PIN_LEN         88
`define ID_VALUE        32'h1234_5679
`define RESET_TMS_EDGES 3'h5
`define TCK_HALF_CYCLES 4'h5
`define SHIFT_CNT_W     7
`endif

// >>> logic/scan_port_pkg.sv
// Types shared by both ends of the boundary-scan test port
`default_nettype none
package scan_port_pkg;
   typedef enum logic [15:0] {
      TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
      SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
      UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
      E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
   } tap_state_t;

   function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
      unique case (s)
         TLR:  return tms ? TLR  : RTI;
         RTI:  return tms ? SDRS : RTI;
         SDRS: return tms ? SIRS : CDR;
         CDR:  return tms ? E1DR : SDR;
         SDR:  return tms ? E1DR : SDR;
         E1DR: return tms ? UDR  : PDR;
         PDR:  return tms ? E2DR : PDR;
         E2DR: return tms ? UDR  : SDR;
         UDR:  return tms ? SDRS : RTI;
         SIRS: return tms ? TLR  : CIR;
         CIR:  return tms ? E1IR : SIR;
         SIR:  return tms ? E1IR : SIR;
         E1IR: return tms ? UIR  : PIR;
         PIR:  return tms ? E2IR : PIR;
         E2IR: return tms ? UIR  : SIR;
         UIR:  return tms ? SDRS : RTI;
         default: return TLR;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> logic/scan_link_if.sv
// Four-wire scan link joining the test controller and the device port
`default_nettype none
interface scan_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo_o;
   logic tdo_oe;
   // A released line shows the inverse, so a read of an idle wire is never mistaken for data
   wire  tdo = tdo_oe ? tdo_o : ~tdo_o;
   modport device (input tck, tms, tdi, output tdo_o, tdo_oe);
   modport controller (output tck, tms, tdi, input tdo);
endinterface
`default_nettype wire

// >>> logic/scan_sync.sv
// Two-stage synchroniser with rise and fall detection for link inputs
`default_nettype none
module scan_sync
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~last_q;
   assign fall  = ~sync_q & last_q;
endmodule
`default_nettype wire

// >>> logic/scan_device.sv
// Device end of the boundary-scan port: TAP, instructions, boundary chain
`default_nettype none
`include "scan_port_map.svh"
module scan_device
   import scan_port_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 sys_rst,
   scan_link_if.device               link,
   input  wire logic [`PIN_LEN-1:0]  pin_sample,
   output logic      [`PIN_LEN-1:0]  pin_drive,
   output logic                      pin_drive_en,
   output logic                      mem_out_float
);
   logic tck_lvl;
   logic tck_rise;
   logic tck_fall;
   logic tms_lvl;
   logic tdi_lvl;

   scan_sync u_tck (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(link.tck),
                    .level(tck_lvl), .rise(tck_rise), .fall(tck_fall));
   scan_sync u_tms (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(link.tms),
                    .level(tms_lvl), .rise(), .fall());
   scan_sync u_tdi (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(link.tdi),
                    .level(tdi_lvl), .rise(), .fall());

   tap_state_t                   state_q;
   logic [`IR_LEN-1:0]           ir_shift_q;
   logic [`IR_LEN-1:0]           ir_q;
   logic [`ID_LEN-1:0]           id_shift_q;
   logic                         bypass_q;
   logic [`BSR_LEN-1:0]          bsr_shift_q;
   logic [`BSR_LEN-1:0]          bsr_hold_q;
   logic                         tdo_q;
   logic                         tdo_oe_q;
   logic                         tdo_d;
   logic                         sel_bsr;
   logic [`PIN_LEN-1:0]          pin_meta_q;
   logic [`PIN_LEN-1:0]          pin_sync_q;

   // Pin levels come from another domain and pass two flip-flops first
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= pin_sample;
         pin_sync_q <= pin_meta_q;
      end
   end

   // Reserved codes fall to bypass so a stray code never breaks the chain
   function automatic logic uses_bsr(input logic [`IR_LEN-1:0] code);
      return code == `INSN_EXTEST || code == `INSN_SAMPLE_Z || code == `INSN_SAMPLE;
   endfunction

   assign sel_bsr = uses_bsr(ir_q);

   // Five TMS-high edges reach TLR from any state via the graph itself
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         state_q <= TLR;
      else if (tck_rise)
         state_q <= tap_next(state_q, tms_lvl);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ir_shift_q <= `IR_CAPTURE_PAT;
         ir_q       <= `INSN_IDCODE;
      end
      else if (tck_rise)
      begin
         unique case (state_q)
            TLR: ir_q <= `INSN_IDCODE;
            CIR: ir_shift_q <= `IR_CAPTURE_PAT;
            SIR: ir_shift_q <= {tdi_lvl, ir_shift_q[`IR_LEN-1:1]};
            UIR: ir_q <= ir_shift_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         id_shift_q <= '0;
         bypass_q   <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (state_q == CDR)
         begin
            id_shift_q <= `ID_VALUE;
            bypass_q   <= 1'b0;
         end
         else if (state_q == SDR)
         begin
            id_shift_q <= {tdi_lvl, id_shift_q[`ID_LEN-1:1]};
            bypass_q   <= tdi_lvl;
         end
      end
   end

   // Capture keeps the shifted tristate cell so a capture cannot clear it
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         bsr_shift_q <= {1'b1, {`PIN_LEN{1'b0}}};
      else if (state_q == TLR)
         bsr_shift_q[`BSR_OE_BIT] <= 1'b1;
      else if (tck_rise && sel_bsr)
      begin
         if (state_q == CDR)
            bsr_shift_q <= {bsr_shift_q[`BSR_OE_BIT], pin_sync_q};
         else if (state_q == SDR)
            bsr_shift_q <= {tdi_lvl, bsr_shift_q[`BSR_LEN-1:1]};
      end
   end

   // Update latches on the falling test-clock edge as the standard cell does
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         bsr_hold_q <= {1'b1, {`PIN_LEN{1'b0}}};
      else if (state_q == TLR)
         bsr_hold_q[`BSR_OE_BIT] <= 1'b1;
      else if (tck_fall && state_q == UDR && sel_bsr)
         bsr_hold_q <= bsr_shift_q;
   end

   always_comb
   begin
      tdo_d = bypass_q;
      if (state_q == SIR)
         tdo_d = ir_shift_q[0];
      else if (sel_bsr)
         tdo_d = bsr_shift_q[0];
      else if (ir_q == `INSN_IDCODE)
         tdo_d = id_shift_q[0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_q    <= tdo_d;
         tdo_oe_q <= state_q == SIR || state_q == SDR;
      end
   end

   assign link.tdo_o  = tdo_q;
   assign link.tdo_oe = tdo_oe_q;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_drive     <= '0;
         pin_drive_en  <= 1'b0;
         mem_out_float <= 1'b0;
      end
      else
      begin
         pin_drive     <= bsr_hold_q[`PIN_LEN-1:0];
         pin_drive_en  <= ir_q == `INSN_EXTEST && bsr_hold_q[`BSR_OE_BIT];
         mem_out_float <= ir_q == `INSN_SAMPLE_Z ||
                          (ir_q == `INSN_EXTEST && !bsr_hold_q[`BSR_OE_BIT]);
      end
   end
endmodule
`default_nettype wire

// >>> logic/scan_controller.sv
// Controller end: makes the test clock and runs scan sequences on request
`default_nettype none
`include "scan_port_map.svh"
module scan_controller
   import scan_port_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      sys_rst,
   scan_link_if.controller                link,
   input  wire logic                      reset_req,
   input  wire logic                      ir_req,
   input  wire logic                      dr_req,
   input  wire logic [`BSR_LEN-1:0]       shift_in,
   input  wire logic [`SHIFT_CNT_W-1:0]   shift_len,
   output logic                           busy,
   output logic                           done,
   output logic      [`BSR_LEN-1:0]       shift_out
);
   typedef enum logic [3:0] {
      C_IDLE = 4'h1, C_RESET = 4'h2, C_HEAD = 4'h4, C_SHIFT = 4'h8
   } ctl_state_t;

   ctl_state_t              cst_q;
   logic [3:0]              div_q;
   logic                    tck_q;
   logic [`SHIFT_CNT_W-1:0] cnt_q;
   logic [`BSR_LEN-1:0]     data_q;
   logic                    is_ir_q;
   logic                    tdo_meta_q;
   logic                    tdo_q;
   logic                    tms_q;
   logic                    fall_edge;

   // Divider gives a 10 MHz test clock, inside the 20 MHz ceiling
   assign fall_edge = tck_q && div_q == `TCK_HALF_CYCLES - 4'h1;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || cst_q == C_IDLE)
      begin
         div_q <= '0;
         tck_q <= 1'b0;
      end
      else if (div_q == `TCK_HALF_CYCLES - 4'h1)
      begin
         div_q <= '0;
         tck_q <= ~tck_q;
      end
      else
         div_q <= div_q + 4'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tdo_meta_q <= 1'b0;
         tdo_q      <= 1'b0;
      end
      else
      begin
         tdo_meta_q <= link.tdo;
         tdo_q      <= tdo_meta_q;
      end
   end

   // TMS and TDI change on the falling edge; the head walks from idle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cst_q   <= C_IDLE;
         cnt_q   <= '0;
         data_q  <= '0;
         is_ir_q <= 1'b0;
         tms_q   <= 1'b1;
         done    <= 1'b0;
         shift_out <= '0;
      end
      else
      begin
         done <= 1'b0;
         unique case (cst_q)
            C_IDLE:
            begin
               tms_q <= 1'b0;
               if (reset_req)
               begin
                  cst_q <= C_RESET;
                  tms_q <= 1'b1;
                  cnt_q <= `SHIFT_CNT_W'(`RESET_TMS_EDGES);
               end
               else if (ir_req || dr_req)
               begin
                  cst_q   <= C_HEAD;
                  is_ir_q <= ir_req;
                  data_q  <= shift_in;
                  cnt_q   <= ir_req ? `SHIFT_CNT_W'(5) : `SHIFT_CNT_W'(4);
                  tms_q   <= 1'b0;
               end
            end
            C_RESET:
               if (fall_edge)
               begin
                  cnt_q <= cnt_q - 1'b1;
                  if (cnt_q == 1)
                  begin
                     cst_q <= C_IDLE;
                     tms_q <= 1'b0;
                     done  <= 1'b1;
                  end
               end
            C_HEAD:
               if (fall_edge)
               begin
                  cnt_q <= cnt_q - 1'b1;
                  tms_q <= cnt_q == 4 || (is_ir_q && cnt_q == 5);
                  // The last head fall sets the mode bit of the first shift edge
                  if (cnt_q == 1)
                  begin
                     cst_q <= C_SHIFT;
                     cnt_q <= shift_len + `SHIFT_CNT_W'(2);
                     tms_q <= shift_len == `SHIFT_CNT_W'(1);
                  end
               end
            // Each bit is taken one test clock after the device shows it; two tail
            // edges pass the update state and return to idle
            C_SHIFT:
               if (fall_edge)
               begin
                  if (cnt_q >= 3)
                     data_q <= {tdo_q, data_q[`BSR_LEN-1:1]};
                  cnt_q  <= cnt_q - 1'b1;
                  tms_q  <= cnt_q == 4 || cnt_q == 3;
                  if (cnt_q == 1)
                  begin
                     cst_q     <= C_IDLE;
                     tms_q     <= 1'b0;
                     done      <= 1'b1;
                     shift_out <= data_q;
                  end
               end
            default: cst_q <= C_IDLE;
         endcase
      end
   end

   assign link.tck = tck_q;
   assign link.tms = tms_q;
   assign link.tdi = data_q[0];
   assign busy     = cst_q != C_IDLE;
endmodule
`default_nettype wire

// >>> tb/scan_port_monitor.sv
// Checker for the four-wire scan link between controller and device
`default_nettype none
`include "scan_port_map.svh"
module scan_port_monitor
   import scan_port_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe
);
   localparam logic [31:0] id_val = `ID_VALUE;
   logic       tck_q;
   logic       rise;
   logic       in_shift;
   tap_state_t st_q;
   tap_state_t prev_q;
   logic [2:0] ir_sh_q;
   logic [2:0] ir_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // The test clock comes from the same system clock, so plain sampling is exact
   assign rise     = tck && !tck_q;
   assign in_shift = (st_q == SIR) || (st_q == SDR);

   always_ff @(posedge sys_clk)
      tck_q <= sys_rst ? 1'b0 : tck;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_q   <= TLR;
         prev_q <= TLR;
      end
      else if (rise)
      begin
         st_q   <= tap_next(st_q, tms);
         prev_q <= st_q;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rise && st_q == SIR)
         ir_sh_q <= {tdi, ir_sh_q[2:1]};
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || st_q == TLR)
         ir_q <= `INSN_IDCODE;
      else if (rise && st_q == UIR)
         ir_q <= ir_sh_q;
   end

   property p_tdo_float;
      rise |-> (tdo_oe == in_shift);
   endproperty
   a_tdo_float: assert property (p_tdo_float)
      else $error("serial output enable does not match shift state");

   property p_tdo_hold;
      (tck && tck_q) |-> $stable(tdo_o);
   endproperty
   a_tdo_hold: assert property (p_tdo_hold)
      else $error("serial output moved while test clock high");

   property p_capture_ir;
      (rise && st_q == SIR && prev_q == CIR) |-> (tdo_o && tdo_oe);
   endproperty
   a_capture_ir: assert property (p_capture_ir)
      else $error("first instruction bit out is not one");

   property p_id_first;
      (rise && st_q == SDR && prev_q == CDR && ir_q == `INSN_IDCODE) |-> (tdo_o == id_val[0]);
   endproperty
   a_id_first: assert property (p_id_first)
      else $error("first identification bit wrong");

   property p_bypass_first;
      (rise && st_q == SDR && prev_q == CDR && ir_q == `INSN_BYPASS) |-> !tdo_o;
   endproperty
   a_bypass_first: assert property (p_bypass_first)
      else $error("bypass bit not captured low");

   property p_tlr_float;
      (st_q == TLR) |-> !tdo_oe;
   endproperty
   a_tlr_float: assert property (p_tlr_float)
      else $error("serial output driven in reset state");

   property p_tck_high;
      $rose(tck) |-> tck [*2];
   endproperty
   a_tck_high: assert property (p_tck_high)
      else $error("test clock high phase too short");

   property p_tck_low;
      $fell(tck) |-> !tck [*2];
   endproperty
   a_tck_low: assert property (p_tck_low)
      else $error("test clock low phase too short");

   property p_tms_steady;
      ($changed(tms) || $changed(tdi)) |-> !tck;
   endproperty
   a_tms_steady: assert property (p_tms_steady)
      else $error("mode or data line moved while test clock high");
endmodule
`default_nettype wire

// >>> tb/tb_boundary_scan_tap_instructions.sv
// Bench joining controller and device, driving scan sequences and checking results
`default_nettype none
`include "scan_port_map.svh"
module tb_boundary_scan_tap_instructions;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [87:0] pa = 88'h0123_4567_89ab_cdef_fedc_ba;
   localparam logic [87:0] pb = 88'h5a5a_a5a5_3c3c_c3c3_0ff0_f0;
   logic        sys_clk    = 1'b0;
   logic        sys_rst    = 1'b1;
   logic        reset_req  = 1'b0;
   logic        ir_req     = 1'b0;
   logic        dr_req     = 1'b0;
   logic [88:0] shift_in   = 89'h0;
   logic [6:0]  shift_len  = 7'h1;
   logic [87:0] pin_sample = 88'hc3c3_0f0f_9696_6969_a5a5_5a;
   logic        busy;
   logic        done;
   logic [88:0] shift_out;
   logic [87:0] pin_drive;
   logic        pin_drive_en;
   logic        mem_out_float;
   int          n_fail     = 0;
   int          checked    = 0;
   int          cycles     = 0;

   scan_link_if link ();
   scan_device scan_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.device),
      .pin_sample(pin_sample), .pin_drive(pin_drive), .pin_drive_en(pin_drive_en),
      .mem_out_float(mem_out_float));
   scan_controller scan_controller_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link.controller), .reset_req(reset_req), .ir_req(ir_req), .dr_req(dr_req),
      .shift_in(shift_in), .shift_len(shift_len), .busy(busy), .done(done),
      .shift_out(shift_out));
   scan_port_monitor scan_port_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo_o(link.tdo_o),
      .tdo_oe(link.tdo_oe));

   always #5 sys_clk = ~sys_clk;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input logic [88:0] got, input logic [88:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Kind 0 resets the port, 1 shifts the instruction path, 2 the data path
   task automatic xfer(input int kind, input logic [88:0] d, input int n,
                       output logic [88:0] r);
      int i;
      @(negedge sys_clk);
      shift_in = d;
      shift_len = n[6:0];
      reset_req = (kind == 0);
      ir_req = (kind == 1);
      dr_req = (kind == 2);
      @(negedge sys_clk);
      reset_req = 1'b0;
      ir_req = 1'b0;
      dr_req = 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 20000)
      begin
         @(negedge sys_clk);
         i++;
      end
      // Short shifts land in the top bits of the result
      r = shift_out >> (`BSR_LEN - n);
   endtask

   task automatic outs(input logic [1:0] exp);
      chk({87'h0, pin_drive_en, mem_out_float}, {87'h0, exp});
   endtask

   initial
   begin
      logic [88:0] r;
      logic [2:0]  codes [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      xfer(2, 89'h0, 32, r);
      chk(r, 89'(`ID_VALUE));
      outs(2'h0);
      xfer(1, 89'h4, 3, r);
      chk(r & 89'h3, 89'h1);
      xfer(2, {1'b0, pa}, 89, r);
      chk(r, {1'b1, pin_sample});
      chk({1'b0, pin_drive}, {1'b0, pa});
      outs(2'h0);
      xfer(1, 89'h0, 3, r);
      outs(2'h1);
      pin_sample = ~pin_sample;
      xfer(2, {1'b1, pb}, 89, r);
      chk(r, {1'b0, pin_sample});
      chk({1'b0, pin_drive}, {1'b0, pb});
      outs(2'h2);
      xfer(1, 89'h2, 3, r);
      outs(2'h1);
      xfer(2, {1'b0, pa}, 89, r);
      chk(r, {1'b1, pin_sample});
      foreach (codes[k])
      begin
         xfer(1, {86'h0, codes[k]}, 3, r);
         xfer(2, 89'ha5, 8, r);
         chk(r, 89'h4a);
      end
      xfer(1, 89'h1, 3, r);
      xfer(2, 89'h0, 32, r);
      chk(r, 89'(`ID_VALUE));
      xfer(1, 89'h0, 3, r);
      xfer(2, {1'b0, pa}, 89, r);
      outs(2'h1);
      xfer(0, 89'h0, 1, r);
      outs(2'h0);
      xfer(2, 89'h0, 32, r);
      chk(r, 89'(`ID_VALUE));
      xfer(1, 89'h0, 3, r);
      outs(2'h2);
      give_verdict();
   end
endmodule
`default_nettype wire
